// ==== hw/boot_remap_nvm_config.sv ====
// Behaviour
// - sram only at its base until remap, then also at zero
// - rom always decodes at its own base
// - flash decodes at its own base, except debug accesses refused while security set
// - boot bit set maps flash at zero until remap
// - boot bit clear maps rom at zero, boot from rom
// - erase pin clears the boot bit
// - nv bits change by set and clear commands, by erase pin and by reset
// - 32 lock regions of 64 pages of 256 bytes
// - program or erase to locked region aborts and raises interrupt
// - set-lock protects a region, clear-lock unprotects it
// - erase pin clears every lock bit
// - security set refuses debug flash accesses
// - security set by command, cleared by erase pin then full erase
// - bit 0 enables brownout detector, erase pin clears it
// - bit 1 enables brownout reset, erase pin clears it
// - calibration bits read-only and untouched by erase pin
// - test pin and port-a lines 0,1 high enter fast programming
// - flash goes to standby when no access is in progress
// - each bank has own controller; reads continue while other busy
// - 256-byte write buffer loaded over a 32-bit interface
// - dual 32-bit prefetch serves sequential 16-bit fetches
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
module boot_remap_nvm_config
  import boot_remap_pkg::*;
#(
  parameter int ERASE_HOLD = ERASE_HOLD_CYC,
  parameter int PROG_TIME = PAGE_PROG_CYC,
  parameter int FERASE_TIME = FULL_ERASE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon register slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // system bus decode
  input wire bus_req_t bus_req,
  output mem_sel_t mem_sel,
  // pins
  input wire logic erase_pin,
  input wire logic test_mode_pin,
  input wire logic port_a_line_zero,
  input wire logic port_a_line_one,
  // instruction fetch and array read
  input wire logic fetch_valid,
  input wire logic [18:0] fetch_addr,
  output logic fetch_hit,
  output logic [15:0] fetch_data,
  output logic array_rd_req,
  output logic [17:0] array_rd_addr,
  input wire logic array_rvalid,
  input wire logic [31:0] array_rdata,
  // program engine
  output logic [BANKS-1:0] prog_start,
  output logic [BANKS-1:0] bank_busy,
  output logic [PAGE_W-1:0] prog_page,
  input wire logic [5:0] buf_rd_idx,
  output logic [31:0] buf_rd_data,
  output logic flash_standby,
  // configuration outputs
  output logic brownout_detector_en,
  output logic brownout_reset_en,
  output logic fast_program_port_en,
  output logic flash_ctrl_irq
);
  // =====================================================
  // pin synchronisers
  logic [3:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge clk_sys) begin
    pin_s1_r <= {erase_pin, test_mode_pin, port_a_line_zero,
                 port_a_line_one};
    pin_s2_r <= pin_s1_r;
  end
  logic erase_s, fpm_s;
  assign erase_s = pin_s2_r[3];
  assign fpm_s = &pin_s2_r[2:0];
  // =====================================================
  // erase pin hold filter
  erase_st_t er_st_r, er_st_nxt;
  logic [23:0] er_cnt_r, er_cnt_nxt;
  logic erase_hit;
  always_comb begin
    er_st_nxt = er_st_r;
    er_cnt_nxt = er_cnt_r;
    erase_hit = 1'b0;
    unique case (er_st_r)
      ER_IDLE: begin
        er_cnt_nxt = 24'h0;
        if (erase_s) er_st_nxt = ER_COUNT;
      end
      ER_COUNT: begin
        if (!erase_s) begin
          er_st_nxt = ER_IDLE;
        end else if (er_cnt_r == 24'(ERASE_HOLD - 1)) begin
          er_st_nxt = ER_FIRED;
          erase_hit = 1'b1;
        end else begin
          er_cnt_nxt = er_cnt_r + 24'h1;
        end
      end
      ER_FIRED: if (!erase_s) er_st_nxt = ER_IDLE;
      default: er_st_nxt = ER_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      er_st_r <= ER_IDLE;
      er_cnt_r <= 24'h0;
    end else begin
      er_st_r <= er_st_nxt;
      er_cnt_r <= er_cnt_nxt;
    end
  end
  // =====================================================
  // avalon handshake
  logic wait_r, wait_nxt, rd_take, wr_take;
  logic [31:0] rdata_r, rdata_nxt;
  assign rd_take = avs_read & ~wait_r;
  assign wr_take = avs_write & ~wait_r;
  // =====================================================
  // configuration state and commands
  logic [GP_BITS-1:0] gp_r, gp_nxt;
  logic [LOCK_REGIONS-1:0] lock_r, lock_nxt;
  logic sec_r, sec_nxt, armed_r, armed_nxt, remap_r, remap_nxt;
  logic lockerr_r, lockerr_nxt, fpm_r;
  logic [BANKS-1:0] start_nxt, start_r;
  logic [PAGE_W-1:0] page_r, page_nxt;
  logic ferase_nxt, ferase_r;
  logic cmd_wr, err_set;
  cmd_op_t op;
  logic [PAGE_W-1:0] arg;
  assign cmd_wr = wr_take && (avs_address == REG_CMD);
  assign op = cmd_op_t'(avs_writedata[CMD_OP_LSB +: 4]);
  assign arg = avs_writedata[CMD_ARG_LSB +: PAGE_W];
  always_comb begin
    gp_nxt = gp_r;
    lock_nxt = lock_r;
    sec_nxt = sec_r;
    armed_nxt = armed_r;
    remap_nxt = remap_r;
    start_nxt = '0;
    ferase_nxt = 1'b0;
    page_nxt = page_r;
    err_set = 1'b0;
    if (cmd_wr) begin
      unique case (op)
        OP_PAGE_PROG, OP_PAGE_ERASE: begin
          if (lock_r[region_of(arg)]) begin
            err_set = 1'b1;
          end else if (!bank_busy[bank_of(arg)]) begin
            start_nxt[bank_of(arg)] = 1'b1;
            page_nxt = arg;
          end
        end
        OP_FULL_ERASE: begin
          if (bank_busy == '0) begin
            start_nxt = '1;
            ferase_nxt = 1'b1;
            page_nxt = '0;
            if (armed_r) begin
              sec_nxt = 1'b0;
              armed_nxt = 1'b0;
            end
          end
        end
        OP_SET_LOCK: lock_nxt[region_of(arg)] = 1'b1;
        OP_CLR_LOCK: lock_nxt[region_of(arg)] = 1'b0;
        OP_SET_GP: if (arg < PAGE_W'(GP_BITS)) gp_nxt[arg[1:0]] = 1'b1;
        OP_CLR_GP: if (arg < PAGE_W'(GP_BITS)) gp_nxt[arg[1:0]] = 1'b0;
        OP_SET_SEC: sec_nxt = 1'b1;
        default: ;
      endcase
    end
    if (wr_take && avs_address == REG_REMAP && avs_writedata[0])
      remap_nxt = 1'b1;
    if (erase_hit) begin
      gp_nxt = GP_RESET;
      lock_nxt = '0;
      armed_nxt = 1'b1;
    end
    // a new error wins over a clear in the same cycle
    lockerr_nxt = err_set | (lockerr_r & ~(wr_take &&
                  avs_address == REG_STATUS &&
                  avs_writedata[ST_LOCKERR]));
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gp_r <= GP_RESET;
      lock_r <= '0;
      sec_r <= 1'b0;
      armed_r <= 1'b0;
      remap_r <= 1'b0;
      lockerr_r <= 1'b0;
      start_r <= '0;
      ferase_r <= 1'b0;
      page_r <= '0;
      fpm_r <= 1'b0;
    end else begin
      gp_r <= gp_nxt;
      lock_r <= lock_nxt;
      sec_r <= sec_nxt;
      armed_r <= armed_nxt;
      remap_r <= remap_nxt;
      lockerr_r <= lockerr_nxt;
      start_r <= start_nxt;
      ferase_r <= ferase_nxt;
      page_r <= page_nxt;
      fpm_r <= fpm_s;
    end
  end
  // =====================================================
  // per-bank controllers
  logic [19:0] busy_cnt_r [BANKS];
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      logic [19:0] cnt_nxt;
      logic busy_r;
      always_comb begin
        cnt_nxt = busy_cnt_r[b];
        if (start_nxt[b])
          cnt_nxt = ferase_nxt ? 20'(FERASE_TIME) : 20'(PROG_TIME);
        else if (busy_cnt_r[b] != 20'h0)
          cnt_nxt = busy_cnt_r[b] - 20'h1;
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          busy_cnt_r[b] <= 20'h0;
          busy_r <= 1'b0;
        end else begin
          busy_cnt_r[b] <= cnt_nxt;
          busy_r <= cnt_nxt != 20'h0;
        end
      end
      assign bank_busy[b] = busy_r;
    end
  endgenerate
  // =====================================================
  // write buffer
  logic [31:0] wbuf [BUF_WORDS];
  logic [31:0] buf_rd_r;
  always_ff @(posedge clk_sys) begin
    if (wr_take && avs_address[6] == REG_BUF_BASE[6])
      wbuf[avs_address[5:0]] <= avs_writedata;
    buf_rd_r <= wbuf[buf_rd_idx];
  end
  // =====================================================
  // register read mux and waitrequest
  always_comb begin
    wait_nxt = ~((avs_read | avs_write) & wait_r);
    rdata_nxt = 32'h0;
    if (avs_read && wait_r) begin
      if (avs_address[6] == REG_BUF_BASE[6]) begin
        rdata_nxt = wbuf[avs_address[5:0]];
      end else begin
        unique case (avs_address)
          REG_STATUS: begin
            rdata_nxt[ST_GP_LSB +: GP_BITS] = gp_r;
            rdata_nxt[ST_SEC] = sec_r;
            rdata_nxt[ST_REMAP] = remap_r;
            rdata_nxt[ST_LOCKERR] = lockerr_r;
            rdata_nxt[ST_BUSY_LSB +: BANKS] = bank_busy;
            rdata_nxt[ST_FPM] = fpm_r;
            rdata_nxt[ST_ARMED] = armed_r;
          end
          REG_LOCKS: rdata_nxt = lock_r;
          REG_CALIB: rdata_nxt = {24'h0, CALIB_VALUE};
          REG_REMAP: rdata_nxt = {31'h0, remap_r};
          default: rdata_nxt = 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rd_take ? rdata_r : rdata_nxt;
    end
  end
  // =====================================================
  // address decode
  mem_sel_t sel_r, sel_nxt;
  always_comb begin
    sel_nxt = '0;
    if (bus_req.valid && bus_req.addr <= UNDEF_LAST) begin
      unique case (bus_req.addr[27:20])
        BOOT_BASE[27:20]: begin
          sel_nxt.sram = remap_r;
          sel_nxt.flash = !remap_r && gp_r[GP_BOOT_FLASH];
          sel_nxt.rom = !remap_r && !gp_r[GP_BOOT_FLASH];
        end
        FLASH_BASE[27:20]: sel_nxt.flash = 1'b1;
        SRAM_BASE[27:20]: sel_nxt.sram = 1'b1;
        ROM_BASE[27:20]: sel_nxt.rom = 1'b1;
        default: sel_nxt.abort = 1'b1;
      endcase
      if (sel_nxt.flash && bus_req.dbg_src && sec_r) begin
        sel_nxt.flash = 1'b0;
        sel_nxt.abort = 1'b1;
      end
    end
  end
  // =====================================================
  // prefetch of two words
  logic [17:0] pf_tag_r [2];
  logic [31:0] pf_dat_r [2];
  logic [1:0] pf_v_r, pf_v_nxt;
  logic pend_r, pend_nxt, ahead_r, ahead_nxt;
  logic [17:0] pend_a_r, pend_a_nxt, fw;
  logic hit_nxt, h0, h1;
  logic [15:0] fdat_nxt;
  assign fw = fetch_addr[18:1];
  assign h0 = pf_v_r[0] && pf_tag_r[0] == fw;
  assign h1 = pf_v_r[1] && pf_tag_r[1] == fw;
  always_comb begin
    pf_v_nxt = pf_v_r;
    pend_nxt = pend_r;
    pend_a_nxt = pend_a_r;
    ahead_nxt = ahead_r;
    hit_nxt = 1'b0;
    fdat_nxt = fetch_data;
    if (fetch_valid && (h0 || h1)) begin
      hit_nxt = 1'b1;
      fdat_nxt = h0 ? (fetch_addr[0] ? pf_dat_r[0][31:16] :
                       pf_dat_r[0][15:0]) :
                      (fetch_addr[0] ? pf_dat_r[1][31:16] :
                       pf_dat_r[1][15:0]);
    end
    if (pend_r && array_rvalid) begin
      pf_v_nxt[pend_a_r[0]] = 1'b1;
      pend_nxt = !ahead_r;
      pend_a_nxt = pend_a_r + 18'h1; // anticipate next word
      ahead_nxt = !ahead_r;
    end else if (!pend_r && fetch_valid && !(h0 || h1)) begin
      pend_nxt = 1'b1;
      pend_a_nxt = fw;
      ahead_nxt = 1'b0;
    end
    if (start_r != '0) pf_v_nxt = '0;
  end
  always_ff @(posedge clk_sys) begin
    if (pend_r && array_rvalid) begin
      pf_tag_r[pend_a_r[0]] <= pend_a_r;
      pf_dat_r[pend_a_r[0]] <= array_rdata;
    end
  end
  // =====================================================
  // output registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pf_v_r <= '0;
      pend_r <= 1'b0;
      pend_a_r <= '0;
      ahead_r <= 1'b0;
      fetch_hit <= 1'b0;
      fetch_data <= 16'h0;
      array_rd_req <= 1'b0;
      array_rd_addr <= '0;
      sel_r <= '0;
      flash_standby <= 1'b1;
    end else begin
      pf_v_r <= pf_v_nxt;
      pend_r <= pend_nxt;
      pend_a_r <= pend_a_nxt;
      ahead_r <= ahead_nxt;
      fetch_hit <= hit_nxt;
      fetch_data <= fdat_nxt;
      array_rd_req <= pend_nxt && !bank_busy[pend_a_nxt[16]];
      array_rd_addr <= pend_a_nxt;
      sel_r <= sel_nxt;
      flash_standby <= !pend_nxt && !fetch_valid && !sel_nxt.flash &&
                       bank_busy == '0 && start_nxt == '0;
    end
  end
  assign mem_sel = sel_r;
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign prog_start = start_r;
  assign prog_page = page_r;
  assign buf_rd_data = buf_rd_r;
  assign brownout_detector_en = gp_r[GP_BOD_EN];
  assign brownout_reset_en = gp_r[GP_BOD_RST];
  assign fast_program_port_en = fpm_r;
  assign flash_ctrl_irq = lockerr_r;
  // =====================================================
  // assertions
  remap_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    remap_r |=> remap_r) else $error("remap dropped");
  rom_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.valid && bus_req.addr[31:20] == ROM_BASE[31:20]
    |=> mem_sel.rom && !mem_sel.abort) else $error("rom miss");
  flash_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.valid && !bus_req.dbg_src &&
    bus_req.addr[31:20] == FLASH_BASE[31:20]
    |=> mem_sel.flash) else $error("flash miss");
  sram_hidden_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.valid && bus_req.addr[31:20] == BOOT_BASE[31:20]
    |=> mem_sel.sram == $past(remap_r)) else $error("sram zero");
  boot_select_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.valid && bus_req.addr[31:20] == BOOT_BASE[31:20] && !remap_r
    && !bus_req.dbg_src |=> mem_sel.flash == $past(gp_r[GP_BOOT_FLASH])
    && mem_sel.rom != $past(gp_r[GP_BOOT_FLASH]))
    else $error("boot select");
  secure_refuse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.valid && bus_req.dbg_src && sec_r &&
    bus_req.addr[31:20] == FLASH_BASE[31:20]
    |=> mem_sel.abort && !mem_sel.flash) else $error("secure");
  undef_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.valid && bus_req.addr >= UNDEF_BASE &&
    bus_req.addr <= UNDEF_LAST |=> mem_sel.abort)
    else $error("undef");
  erase_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    erase_hit |=> gp_r == GP_RESET && lock_r == '0 && armed_r)
    else $error("erase pin");
  lock_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmd_wr && (op == OP_PAGE_PROG || op == OP_PAGE_ERASE) &&
    lock_r[region_of(arg)] |=> flash_ctrl_irq && prog_start == '0)
    else $error("lock abort");
  fast_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (test_mode_pin && port_a_line_zero && port_a_line_one) [*3]
    |=> fast_program_port_en) else $error("fast mode");
  standby_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bank_busy != '0 |-> !flash_standby) else $error("standby");
endmodule

// ==== shared/boot_remap_pkg.sv ====
package boot_remap_pkg;
  // =====================================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int ERASE_HOLD_MS = 220;
  localparam int ERASE_HOLD_CYC = ERASE_HOLD_MS * (CLK_HZ / 1000);
  localparam int PAGE_PROG_MS = 6;
  localparam int PAGE_PROG_CYC = PAGE_PROG_MS * (CLK_HZ / 1000);
  localparam int FULL_ERASE_MS = 15;
  localparam int FULL_ERASE_CYC = FULL_ERASE_MS * (CLK_HZ / 1000);
  // =====================================================
  // memory map, 1 Mbyte areas
  localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
  localparam logic [31:0] ROM_BASE = 32'h0030_0000;
  localparam logic [31:0] UNDEF_BASE = 32'h0040_0000;
  localparam logic [31:0] UNDEF_LAST = 32'h0fff_ffff;
  // =====================================================
  // flash geometry
  localparam int LOCK_REGIONS = 32;
  localparam int PAGES_PER_REGION = 64;
  localparam int PAGE_BYTES = 256;
  localparam int BANKS = 2;
  localparam int BUF_WORDS = PAGE_BYTES / 4;
  localparam int PAGE_W = 11;
  // =====================================================
  // general-purpose nv bits
  localparam int GP_BITS = 3;
  localparam int GP_BOD_EN = 0;
  localparam int GP_BOD_RST = 1;
  localparam int GP_BOOT_FLASH = 2;
  localparam logic [GP_BITS-1:0] GP_RESET = 3'h0;
  localparam logic [7:0] CALIB_VALUE = 8'h5a;
  // =====================================================
  // register word indexes
  localparam logic [6:0] REG_CMD = 7'h00;
  localparam logic [6:0] REG_STATUS = 7'h01;
  localparam logic [6:0] REG_LOCKS = 7'h02;
  localparam logic [6:0] REG_CALIB = 7'h03;
  localparam logic [6:0] REG_REMAP = 7'h04;
  localparam logic [6:0] REG_BUF_BASE = 7'h40;
  // command and status fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ARG_LSB = 8;
  localparam int ST_GP_LSB = 0;
  localparam int ST_SEC = 3;
  localparam int ST_REMAP = 4;
  localparam int ST_LOCKERR = 5;
  localparam int ST_BUSY_LSB = 6;
  localparam int ST_FPM = 8;
  localparam int ST_ARMED = 9;
  // =====================================================
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_PAGE_PROG = 4'h1, OP_PAGE_ERASE = 4'h2,
    OP_FULL_ERASE = 4'h3, OP_SET_LOCK = 4'h4, OP_CLR_LOCK = 4'h5,
    OP_SET_GP = 4'h6, OP_CLR_GP = 4'h7, OP_SET_SEC = 4'h8
  } cmd_op_t;
  typedef enum logic [1:0] {
    ER_IDLE = 2'b00, ER_COUNT = 2'b01, ER_FIRED = 2'b11
  } erase_st_t;
  typedef struct packed {
    logic valid;
    logic dbg_src;
    logic [31:0] addr;
  } bus_req_t;
  typedef struct packed {
    logic flash;
    logic sram;
    logic rom;
    logic abort;
  } mem_sel_t;
  // =====================================================
  function automatic logic [4:0] region_of(input logic [PAGE_W-1:0] pg);
    return pg[PAGE_W-1:6];
  endfunction
  function automatic logic bank_of(input logic [PAGE_W-1:0] pg);
    return pg[PAGE_W-1];
  endfunction
endpackage

// ==== tb/flash_array_model.sv ====
module flash_array_model
#(
  parameter int LAT = 2
) (
  // clock
  input wire logic clk_sys,
  // array read port
  input wire logic array_rd_req,
  input wire logic [17:0] array_rd_addr,
  output logic array_rvalid,
  output logic [31:0] array_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================
  // answer after a few cycles, scramble data between answers
  int cnt = 0;
  always @(posedge clk_sys) begin
    array_rvalid <= 1'b0;
    array_rdata <= ~array_rdata;
    cnt <= array_rd_req ? cnt + 1 : 0;
    if (array_rd_req && cnt == LAT) begin
      array_rvalid <= 1'b1;
      array_rdata <= {array_rd_addr[15:0] ^ 16'hc3c3, array_rd_addr[15:0]};
      cnt <= 0;
    end
  end
endmodule

// ==== tb/test_boot_remap_nvm_config.sv ====
module test_boot_remap_nvm_config
  import boot_remap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================
  // wiring
  localparam logic [3:0] F = 4'h8;
  localparam logic [3:0] S = 4'h4;
  localparam logic [3:0] R = 4'h2;
  localparam logic [3:0] A = 4'h1;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  bus_req_t bus_req = '0;
  mem_sel_t mem_sel;
  logic erase_pin = 1'b0;
  logic test_mode_pin = 1'b0;
  logic port_a_line_zero = 1'b0;
  logic port_a_line_one = 1'b0;
  logic fetch_valid = 1'b0;
  logic [18:0] fetch_addr = 19'h0;
  logic fetch_hit;
  logic [15:0] fetch_data;
  logic array_rd_req;
  logic [17:0] array_rd_addr;
  logic array_rvalid;
  logic [31:0] array_rdata;
  logic [BANKS-1:0] prog_start;
  logic [BANKS-1:0] bank_busy;
  logic [PAGE_W-1:0] prog_page;
  logic [5:0] buf_rd_idx = 6'h0;
  logic [31:0] buf_rd_data;
  logic flash_standby;
  logic brownout_detector_en;
  logic brownout_reset_en;
  logic fast_program_port_en;
  logic flash_ctrl_irq;
  int error_cnt = 0;
  int total_checks = 0;

  boot_remap_nvm_config #(
    .ERASE_HOLD(20),
    .PROG_TIME(200),
    .FERASE_TIME(15)
  ) i_dut (
    .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .bus_req, .mem_sel,
    .erase_pin, .test_mode_pin, .port_a_line_zero, .port_a_line_one,
    .fetch_valid, .fetch_addr, .fetch_hit, .fetch_data, .array_rd_req,
    .array_rd_addr, .array_rvalid, .array_rdata, .prog_start, .bank_busy,
    .prog_page, .buf_rd_idx, .buf_rd_data, .flash_standby,
    .brownout_detector_en, .brownout_reset_en, .fast_program_port_en,
    .flash_ctrl_irq
  );

  flash_array_model #(.LAT(2)) i_array (
    .clk_sys, .array_rd_req, .array_rd_addr, .array_rvalid, .array_rdata
  );

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // =====================================================
  // checking and bus tasks
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    error_cnt++;
    $display("ERROR %0t: wait limit used up", $time);
    tally_and_finish();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    check({31'h0, s}, {31'h0, e});
  endtask
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 50) timeout();
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] e,
                        input logic [31:0] m = 32'hffff_ffff);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  task automatic cmd(input cmd_op_t op, input logic [10:0] arg);
    wr(REG_CMD, {13'h0, arg, 4'h0, op});
  endtask
  task automatic dec(input logic dbg, input logic [31:0] a,
                     input logic [3:0] e, input logic [3:0] m = 4'hf);
    bus_req <= '{valid: 1'b1, dbg_src: dbg, addr: a};
    @(posedge clk_sys);
    #1;
    check({28'h0, mem_sel & m}, {28'h0, e});
    @(posedge clk_sys);
  endtask
  task automatic wait_busy(input logic [1:0] b);
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys);
      if (bank_busy === b) break;
    end
    if (n == 400) timeout();
  endtask
  task automatic fetch(input logic [18:0] a, input logic [15:0] e);
    int n;
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      if (fetch_hit === 1'b1) break;
    end
    if (n == 40) timeout();
    check({16'h0, fetch_data}, {16'h0, e});
    fetch_valid <= 1'b0;
    @(posedge clk_sys);
  endtask
  // =====================================================
  // scenarios
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(REG_STATUS, 32'h0);
    wr(REG_CALIB, 32'h0);
    rd_chk(REG_CALIB, {24'h0, CALIB_VALUE});
    rd_chk(7'h10, 32'h0);
    chk1(flash_standby, 1'b1);
    chk1(fast_program_port_en, 1'b0);
    dec(1'b0, BOOT_BASE, R);
    dec(1'b0, FLASH_BASE, F);
    dec(1'b0, 32'h001f_fffc, F);
    dec(1'b0, SRAM_BASE, S);
    dec(1'b0, ROM_BASE, R);
    dec(1'b0, UNDEF_BASE, A);
    dec(1'b0, UNDEF_LAST, A);
    for (int i = 0; i < 3; i++) cmd(OP_SET_GP, 11'(i));
    rd_chk(REG_STATUS, 32'h7);
    chk1(brownout_detector_en, 1'b1);
    chk1(brownout_reset_en, 1'b1);
    dec(1'b0, BOOT_BASE, F);
    dec(1'b0, ROM_BASE, R);
    cmd(OP_CLR_GP, 11'h1);
    cmd(OP_SET_GP, 11'h3);
    rd_chk(REG_STATUS, 32'h5);
    chk1(brownout_reset_en, 1'b0);
    cmd(OP_SET_LOCK, 11'h7c0);
    rd_chk(REG_LOCKS, 32'h8000_0000);
    cmd(OP_PAGE_PROG, 11'h7ff);
    repeat (4) @(posedge clk_sys);
    chk1(flash_ctrl_irq, 1'b1);
    check({30'h0, bank_busy}, 32'h0);
    rd_chk(REG_STATUS, 32'h25);
    wr(REG_STATUS, 32'h20);
    cmd(OP_CLR_LOCK, 11'h7c0);
    cmd(OP_SET_LOCK, 11'h040);
    rd_chk(REG_LOCKS, 32'h2);
    chk1(flash_ctrl_irq, 1'b0);
    cmd(OP_PAGE_ERASE, 11'h07f);
    chk1(flash_ctrl_irq, 1'b1);
    check({30'h0, prog_start}, 32'h0);
    wr(REG_STATUS, 32'h20);
    wr(REG_BUF_BASE + 7'h1, 32'h1234_5678);
    buf_rd_idx <= 6'h1;
    repeat (2) @(posedge clk_sys);
    check(buf_rd_data, 32'h1234_5678);
    cmd(OP_PAGE_PROG, 11'h400);
    check({30'h0, prog_start}, 32'h2);
    wait_busy(2'b10);
    chk1(flash_standby, 1'b0);
    check({21'h0, prog_page}, 32'h400);
    fetch(19'h1, 16'hc3c3);
    fetch(19'h2, 16'h0001);
    fetch(19'h3, 16'hc3c2);
    chk1(bank_busy[1], 1'b1);
    wait_busy(2'b00);
    wr(REG_REMAP, 32'h1);
    rd_chk(REG_REMAP, 32'h1);
    dec(1'b0, BOOT_BASE, S);
    cmd(OP_SET_SEC, 11'h0);
    rd_chk(REG_STATUS, 32'h1d);
    dec(1'b1, FLASH_BASE, 4'h0, F);
    dec(1'b0, FLASH_BASE, F);
    erase_pin <= 1'b1;
    repeat (40) @(posedge clk_sys);
    erase_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd_chk(REG_STATUS, 32'h218);
    rd_chk(REG_LOCKS, 32'h0);
    rd_chk(REG_CALIB, {24'h0, CALIB_VALUE});
    chk1(brownout_detector_en, 1'b0);
    cmd(OP_FULL_ERASE, 11'h0);
    wait_busy(2'b11);
    wait_busy(2'b00);
    rd_chk(REG_STATUS, 32'h0, 32'h8);
    test_mode_pin <= 1'b1;
    port_a_line_zero <= 1'b1;
    port_a_line_one <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk1(fast_program_port_en, 1'b1);
    test_mode_pin <= 1'b0;
    bus_req <= '0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd_chk(REG_REMAP, 32'h0);
    dec(1'b0, BOOT_BASE, R);
    tally_and_finish();
  end
endmodule
